// ==== dv/plc_model.sv ====
// avalon-mm master standing in for the polling controller
`timescale 1ns/1ps
module plc_model (
   input  wire logic        clk_sys_i,
   input  wire logic [31:0] readdata_i,
   input  wire logic        waitrequest_i,
   output logic      [4:0]  address_o,
   output logic             read_o,
   output logic             write_o,
   output logic      [31:0] writedata_o,
   output logic      [3:0]  byteenable_o
);
   // ------------------------------
   // bus transfers
   // ------------------------------
   initial begin
      address_o    = 5'h1F;
      read_o       = 1'b0;
      write_o      = 1'b0;
      writedata_o  = 32'h0000_0000;
      byteenable_o = 4'h0;
   end

   // prompt cyclic polling
   // one request, held until waitrequest is seen low at an edge
   task automatic xfer(input logic is_wr, input logic [4:0] a, input logic [31:0] d,
                       input logic [3:0] be, output logic [31:0] q);
      @(posedge clk_sys_i);
      address_o    <= a;
      read_o       <= ~is_wr;
      write_o      <= is_wr;
      writedata_o  <= d;
      byteenable_o <= be;
      do begin
         @(posedge clk_sys_i);
      end while (waitrequest_i !== 1'b0);
      q = readdata_i;
      read_o      <= 1'b0;
      write_o     <= 1'b0;
      // released lines turn over so no stale value looks valid
      address_o   <= ~a;
      writedata_o <= ~d;
   endtask

   task automatic rd(input logic [4:0] a, output logic [31:0] q);
      xfer(1'b0, a, 32'h0000_0000, 4'hF, q);
   endtask

   task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
      logic [31:0] dummy;
      xfer(1'b1, a, d, be, dummy);
   endtask

   function automatic int net_move(input logic [7:0] f0, b0, f1, b1);
      logic [7:0] df;
      logic [7:0] db;
      df = f1 - f0;
      db = b1 - b0;
      return int'(df) - int'(db);
   endfunction
endmodule

// ==== dv/testbench.sv ====
// self-checking bench for the operator panel input image
`timescale 1ns/1ps
module testbench
   import panel_image_pkg::*;
;
   logic        clk_sys;
   logic        rst;
   logic [4:0]  address;
   logic        read;
   logic        write;
   logic [31:0] writedata;
   logic [3:0]  byteenable;
   logic [31:0] readdata;
   logic        waitrequest;
   logic [17:0] func_key;
   logic        key_cw;
   logic        key_ccw;
   logic        btn_l;
   logic        btn_r;
   logic        enc_fwd;
   logic        enc_back;
   logic [17:0] func_lamp;
   logic [17:0] prev;
   logic        lamp_l;
   logic        lamp_r;
   logic [31:0] q;
   logic [31:0] c0;
   logic [17:0] fk;
   logic        bad;
   int          n_mismatch;
   int          checks_done;
   int          nf;
   int          ns;

   // short flash periods keep the lamp test brief
   panel_image #(.FAST_HALF_CYCLES(8), .SLOW_HALF_CYCLES(20)) u_panel_image (
      .clk_sys_i(clk_sys), .rst_i(rst), .address_i(address), .read_i(read),
      .write_i(write), .writedata_i(writedata), .byteenable_i(byteenable),
      .readdata_o(readdata), .waitrequest_o(waitrequest), .func_key_i(func_key),
      .key_cw_i(key_cw), .key_ccw_i(key_ccw), .left_lit_button_i(btn_l),
      .right_lit_button_i(btn_r), .enc_fwd_i(enc_fwd), .enc_back_i(enc_back),
      .func_lamp_o(func_lamp), .left_lamp_o(lamp_l), .right_lamp_o(lamp_r));

   plc_model u_plc (
      .clk_sys_i(clk_sys), .readdata_i(readdata), .waitrequest_i(waitrequest),
      .address_o(address), .read_o(read), .write_o(write),
      .writedata_o(writedata), .byteenable_o(byteenable));

   // ------------------------------
   // helpers
   // ------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic give_verdict();
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // one encoder pulse, long enough for the synchroniser
   task automatic pulse(input logic fwd);
      enc_fwd  <= fwd;
      enc_back <= ~fwd;
      repeat (4) @(posedge clk_sys);
      enc_fwd  <= 1'b0;
      enc_back <= 1'b0;
      repeat (4) @(posedge clk_sys);
   endtask

   // hang guard, far beyond the expected run
   initial begin
      repeat (20000) @(posedge clk_sys);
      n_mismatch++;
      give_verdict();
   end

   // ------------------------------
   // main sequence
   // ------------------------------
   initial begin
      rst = 1'b1;
      {func_key, key_cw, key_ccw, btn_l, btn_r, enc_fwd, enc_back} = '0;
      n_mismatch = 0;
      checks_done = 0;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      u_plc.rd(ADDR_COUNT, q);
      check("count_reset", q, ZERO_WORD);
      u_plc.rd(5'h1C, q);
      check("unmapped", q, ZERO_WORD);
      for (int i = 0; i < 3; i++) begin
         fk = 18'h2_A5A5 >> i;
         func_key <= fk;
         key_cw   <= (i == 1);
         key_ccw  <= (i == 2);
         btn_l    <= (i != 2);
         btn_r    <= (i != 1);
         repeat (4) @(posedge clk_sys);
         u_plc.rd(ADDR_IMAGE, q);
         check("image", q, {3'b0, i != 1, 1'b0, i != 2, i == 2, i == 1, 6'b0, fk});
      end
      repeat (3) pulse(1'b1);
      pulse(1'b0);
      u_plc.rd(ADDR_COUNT, q);
      check("count", q, 32'h0000_0103);
      c0 = q;
      repeat (254) pulse(1'b1);
      repeat (2) pulse(1'b0);
      u_plc.rd(ADDR_COUNT, q);
      check("count_wrap", q, 32'h0000_0301);
      check("net", 32'(u_plc.net_move(c0[7:0], c0[15:8], q[7:0], q[15:8])), 32'h0000_00FC);
      u_plc.wr(ADDR_COUNT, 32'hFFFF_FFFF, 4'hF);
      u_plc.rd(ADDR_COUNT, q);
      check("count_preset", q, 32'h0000_0301);
      u_plc.wr(ADDR_BTN_LAMP, 32'h0000_0002, 4'hF);
      repeat (2) @(posedge clk_sys);
      check("lamps_left", {30'h0, lamp_l, lamp_r}, 32'h0000_0002);
      u_plc.wr(ADDR_BTN_LAMP, 32'h0000_0004, 4'hF);
      repeat (2) @(posedge clk_sys);
      check("lamps_right", {30'h0, lamp_l, lamp_r}, 32'h0000_0001);
      // all four lamp codes: off, fast, slow, on
      u_plc.wr(ADDR_FK_LAMP_LO, 32'h0000_00E4, 4'hF);
      u_plc.wr(ADDR_FK_LAMP_HI, 32'h0000_000C, 4'hF);
      repeat (2) @(posedge clk_sys);
      {nf, ns, bad} = '0;
      prev = func_lamp;
      repeat (80) begin
         @(posedge clk_sys);
         nf += int'(func_lamp[1] != prev[1]);
         ns += int'(func_lamp[2] != prev[2]);
         bad |= func_lamp[0] | ~func_lamp[3] | ~func_lamp[17];
         prev = func_lamp;
      end
      check("fast_toggles", 32'(nf), 32'h0000_000A);
      check("slow_toggles", 32'(ns), 32'h0000_0004);
      check("off_on_keys", {31'h0, bad}, ZERO_WORD);
      u_plc.wr(ADDR_FK_LAMP_LO, 32'hFFFF_FFFF, 4'h2);
      u_plc.rd(ADDR_FK_LAMP_LO, q);
      check("lamp_lanes", q, 32'h0000_FFE4);
      // restore on link up, then change-only updates
      func_key <= 18'h0_0003;
      {key_cw, key_ccw, btn_l, btn_r} <= 4'h0;
      u_plc.wr(ADDR_RESTORE, 32'hFFFC_0004, 4'hF);
      u_plc.rd(ADDR_IMAGE, q);
      check("image_unlinked", q, 32'h0000_0003);
      u_plc.wr(ADDR_LINK, 32'h0000_0001, 4'hF);
      u_plc.rd(ADDR_IMAGE, q);
      check("image_restored", q, 32'h1700_0004);
      func_key <= 18'h0_0013;
      repeat (4) @(posedge clk_sys);
      u_plc.rd(ADDR_IMAGE, q);
      check("image_changed", q, 32'h1700_0014);
      give_verdict();
   end
endmodule

// ==== rtl/panel_image.sv ====
// operator panel input image and lamp command logic with avalon-mm slave
// Operation
// - key switch reported as two bits: centre 00, clockwise 01, counter-clockwise 10
// - pushbutton status bit is 1 while held, 0 while released
// - pushbutton lamp dark on command 0, steadily lit on command 1
// - both handwheel count bytes clear to zero at start-up
// - forward and backward pulses kept in separate unsigned bytes, bit 0 lsb
// - each pulse bumps only its direction byte; 255 wraps to 0
// - counters cannot be preset; only pulses and start-up change them
// - counting keeps up with 200 pulses per second, 50 per turn
// - function key lamp command: 00 off, 01 fast, 10 slow, 11 on
// - on link up, control bits load the controller's previous values
// - after link up, a bit updates only when its element changes
// - image bytes: keys 1-8, 9-16, 17-18, then switch and buttons
// - function key status bit is 1 while pressed, 0 when released
`timescale 1ns/1ps
module panel_image
   import panel_image_pkg::*;
#(
   parameter int unsigned FAST_HALF_CYCLES = FAST_HALF_CYC,
   parameter int unsigned SLOW_HALF_CYCLES = SLOW_HALF_CYC
) (
   input  wire logic        clk_sys_i,
   input  wire logic        rst_i,
   // avalon-mm slave
   input  wire logic [4:0]  address_i,
   input  wire logic        read_i,
   input  wire logic        write_i,
   input  wire logic [31:0] writedata_i,
   input  wire logic [3:0]  byteenable_i,
   output logic      [31:0] readdata_o,
   output logic             waitrequest_o,
   // panel pins
   input  wire logic [17:0] func_key_i,
   input  wire logic        key_cw_i,
   input  wire logic        key_ccw_i,
   input  wire logic        left_lit_button_i,
   input  wire logic        right_lit_button_i,
   input  wire logic        enc_fwd_i,
   input  wire logic        enc_back_i,
   output logic      [17:0] func_lamp_o,
   output logic             left_lamp_o,
   output logic             right_lamp_o
);

   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   logic [23:0]      raw_w;
   logic [23:0]      lvl_w;
   logic [23:0]      prv_w;
   logic [17:0]      fk_lvl_w;
   logic [1:0]       sw_lvl_w;
   logic [1:0]       btn_lvl_w;
   logic             fwd_pulse_w;
   logic             back_pulse_w;
   logic [7:0]       fwd_cnt_w;
   logic [7:0]       back_cnt_w;
   logic [31:0]      samp_w;
   logic [31:0]      samp_prev_w;
   logic [31:0]      chg_w;
   logic [31:0]      image_ff;
   logic [31:0]      nxt_image;
   logic [31:0]      restore_ff;
   logic             link_ff;
   logic             link_prev_ff;
   logic             link_rise_w;
   logic [1:0]       btn_cmd_ff;
   logic [35:0]      fk_cmd_ff;
   logic [DIV_W-1:0] fast_div_ff;
   logic [DIV_W-1:0] slow_div_ff;
   logic             fast_ph_ff;
   logic             slow_ph_ff;
   logic             fast_tick_w;
   logic             slow_tick_w;
   logic [17:0]      nxt_func_lamp;
   logic             acc_w;
   logic             wr_go_w;
   logic [31:0]      wmask_w;
   logic [31:0]      rd_mux_w;
   logic             sel_image_w;
   logic             sel_count_w;
   logic             sel_btn_w;
   logic             sel_fk_lo_w;
   logic             sel_fk_hi_w;
   logic             sel_link_w;
   logic             sel_rest_w;
   logic             first_ff;

   // ---------------------------------------------------------------
   // input synchronisation
   // ---------------------------------------------------------------
   assign raw_w = {enc_back_i, enc_fwd_i, right_lit_button_i, left_lit_button_i,
                   key_ccw_i, key_cw_i, func_key_i};

   sync_edge #(
      .W (24)
   ) u_sync (
      .clk_sys_i (clk_sys_i),
      .rst_i     (rst_i),
      .async_i   (raw_w),
      .level_o   (lvl_w),
      .prev_o    (prv_w)
   );

   assign fk_lvl_w  = lvl_w[17:0];
   assign sw_lvl_w  = lvl_w[19:18];
   assign btn_lvl_w = lvl_w[21:20];
   assign fwd_pulse_w  = lvl_w[22] & ~prv_w[22];
   assign back_pulse_w = lvl_w[23] & ~prv_w[23];

   // ---------------------------------------------------------------
   // handwheel counters
   // ---------------------------------------------------------------
   // pulses at 200 per second are far slower than three clock cycles
   // each direction has its own counter
   wrap_count8 u_fwd_cnt (
      .clk_sys_i (clk_sys_i),
      .rst_i     (rst_i),
      .inc_i     (fwd_pulse_w),
      .count_o   (fwd_cnt_w)
   );

   // both counters clear on reset, no preset path
   wrap_count8 u_back_cnt (
      .clk_sys_i (clk_sys_i),
      .rst_i     (rst_i),
      .inc_i     (back_pulse_w),
      .count_o   (back_cnt_w)
   );

   // ---------------------------------------------------------------
   // control element image
   // ---------------------------------------------------------------
   // byte packing of keys, switch and buttons
   // switch code, pressed reads as 1
   always_comb begin
      samp_w = ZERO_WORD;
      samp_w[FK_LSB +: NUM_FKEYS] = fk_lvl_w;
      samp_w[SW_LOW_BIT]          = sw_lvl_w[0];
      samp_w[SW_HIGH_BIT]         = sw_lvl_w[1];
      samp_w[BTN_LEFT_BIT]        = btn_lvl_w[0];
      samp_w[BTN_RIGHT_BIT]       = btn_lvl_w[1];
   end

   always_comb begin
      samp_prev_w = ZERO_WORD;
      samp_prev_w[FK_LSB +: NUM_FKEYS] = prv_w[17:0];
      samp_prev_w[SW_LOW_BIT]          = prv_w[18];
      samp_prev_w[SW_HIGH_BIT]         = prv_w[19];
      samp_prev_w[BTN_LEFT_BIT]        = prv_w[20];
      samp_prev_w[BTN_RIGHT_BIT]       = prv_w[21];
   end

   assign chg_w       = samp_w ^ samp_prev_w;
   assign link_rise_w = link_ff & ~link_prev_ff;

   // link rise loads the restored word; later only changes pass
   assign nxt_image = !link_ff    ? samp_w :
                      link_rise_w ? (restore_ff & IMAGE_MASK) :
                      (image_ff & ~chg_w) | (samp_w & chg_w);

   // local sampling runs until the link is up, so start-up values still show
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         image_ff     <= ZERO_WORD;
         link_prev_ff <= 1'b0;
         first_ff     <= 1'b1;
      end else begin
         image_ff     <= nxt_image;
         link_prev_ff <= link_ff;
         first_ff     <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // flash rate dividers
   // ---------------------------------------------------------------
   assign fast_tick_w = (fast_div_ff == DIV_W'(FAST_HALF_CYCLES - 1));
   assign slow_tick_w = (slow_div_ff == DIV_W'(SLOW_HALF_CYCLES - 1));

   // free-running phases, so all lamps flashing at the same rate blink in step
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         fast_div_ff <= '0;
         slow_div_ff <= '0;
         fast_ph_ff  <= 1'b0;
         slow_ph_ff  <= 1'b0;
      end else begin
         fast_div_ff <= fast_tick_w ? '0 : DIV_W'(fast_div_ff + 1'b1);
         slow_div_ff <= slow_tick_w ? '0 : DIV_W'(slow_div_ff + 1'b1);
         fast_ph_ff  <= fast_ph_ff ^ fast_tick_w;
         slow_ph_ff  <= slow_ph_ff ^ slow_tick_w;
      end
   end

   // ---------------------------------------------------------------
   // lamp drive
   // ---------------------------------------------------------------
   // two-bit command per function key lamp
   always_comb begin
      for (int k = 0; k < NUM_FKEYS; k++) begin
         case (fk_cmd_ff[2*k +: 2])
            LAMP_OFF:  nxt_func_lamp[k] = 1'b0;
            LAMP_FAST: nxt_func_lamp[k] = fast_ph_ff;
            LAMP_SLOW: nxt_func_lamp[k] = slow_ph_ff;
            default:   nxt_func_lamp[k] = 1'b1;
         endcase
      end
   end

   // pushbutton lamps follow their command bits
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         func_lamp_o  <= '0;
         left_lamp_o  <= 1'b0;
         right_lamp_o <= 1'b0;
      end else begin
         func_lamp_o  <= nxt_func_lamp;
         left_lamp_o  <= btn_cmd_ff[0];
         right_lamp_o <= btn_cmd_ff[1];
      end
   end

   // ---------------------------------------------------------------
   // avalon-mm slave
   // ---------------------------------------------------------------
   // a request is taken while waitrequest is high, answered one cycle later
   assign acc_w   = (read_i | write_i) & waitrequest_o;
   assign wr_go_w = write_i & ~waitrequest_o;
   assign wmask_w = {{8{byteenable_i[3]}}, {8{byteenable_i[2]}},
                     {8{byteenable_i[1]}}, {8{byteenable_i[0]}}};

   assign sel_image_w = (address_i == ADDR_IMAGE);
   assign sel_count_w = (address_i == ADDR_COUNT);
   assign sel_btn_w   = (address_i == ADDR_BTN_LAMP);
   assign sel_fk_lo_w = (address_i == ADDR_FK_LAMP_LO);
   assign sel_fk_hi_w = (address_i == ADDR_FK_LAMP_HI);
   assign sel_link_w  = (address_i == ADDR_LINK);
   assign sel_rest_w  = (address_i == ADDR_RESTORE);

   // count word: forward byte low, backward byte above
   assign rd_mux_w =
      sel_image_w ? image_ff :
      sel_count_w ? {16'h0000, back_cnt_w, fwd_cnt_w} :
      sel_btn_w   ? {29'h0000_0000, btn_cmd_ff[1], btn_cmd_ff[0], 1'b0} :
      sel_fk_lo_w ? fk_cmd_ff[31:0] :
      sel_fk_hi_w ? {28'h000_0000, fk_cmd_ff[35:32]} :
      sel_link_w  ? {31'h0000_0000, link_ff} :
      sel_rest_w  ? restore_ff :
                    ZERO_WORD;   // unmapped reads return zero

   // waitrequest low for exactly one cycle per request
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         waitrequest_o <= 1'b1;
         readdata_o    <= ZERO_WORD;
      end else begin
         waitrequest_o <= ~acc_w;
         if (acc_w && read_i) begin
            readdata_o <= rd_mux_w;
         end
      end
   end

   // writable registers; count and image words ignore writes
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         btn_cmd_ff <= 2'h0;
         fk_cmd_ff  <= '0;
         link_ff    <= 1'b0;
         restore_ff <= ZERO_WORD;
      end else if (wr_go_w) begin
         if (sel_btn_w && byteenable_i[0]) begin
            btn_cmd_ff <= {writedata_i[LAMP_RIGHT_BIT], writedata_i[LAMP_LEFT_BIT]};
         end
         if (sel_fk_lo_w) begin
            fk_cmd_ff[31:0] <= (fk_cmd_ff[31:0] & ~wmask_w) | (writedata_i & wmask_w);
         end
         if (sel_fk_hi_w && byteenable_i[0]) begin
            fk_cmd_ff[35:32] <= writedata_i[3:0];
         end
         if (sel_link_w && byteenable_i[0]) begin
            link_ff <= writedata_i[LINK_BIT];
         end
         if (sel_rest_w) begin
            restore_ff <= (restore_ff & ~wmask_w) | (writedata_i & wmask_w);
         end
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   sequence s_link_rise;
      !link_ff ##1 link_ff;
   endsequence

   sequence s_one_answer;
      !waitrequest_o ##1 waitrequest_o;
   endsequence

   a_switch_code: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      (!link_ff && !$past(link_ff)) |->
         image_ff[SW_HIGH_BIT:SW_LOW_BIT] == $past(sw_lvl_w))
      else $error("switch code does not follow the synchronised switch");

   a_button_status: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      (!link_ff && !$past(link_ff)) |->
         (image_ff[BTN_LEFT_BIT] == $past(btn_lvl_w[0])) &&
         (image_ff[BTN_RIGHT_BIT] == $past(btn_lvl_w[1])))
      else $error("pushbutton status bit wrong");

   a_button_lamp: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      ##1 (left_lamp_o == $past(btn_cmd_ff[0])) && (right_lamp_o == $past(btn_cmd_ff[1])))
      else $error("pushbutton lamp does not follow its command");

   a_count_start: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      first_ff |-> (fwd_cnt_w == 8'h00) && (back_cnt_w == 8'h00))
      else $error("handwheel counts not zero after start-up");

   a_fwd_wrap: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      (fwd_pulse_w && fwd_cnt_w == 8'hFF) |=> (fwd_cnt_w == 8'h00) && $stable(back_cnt_w))
      else $error("forward count did not wrap from 255 to 0");

   a_back_step: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      back_pulse_w |=> back_cnt_w == 8'($past(back_cnt_w) + 8'h01))
      else $error("backward count did not step by one");

   a_count_hold: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      (!fwd_pulse_w && !back_pulse_w) |=> $stable(fwd_cnt_w) && $stable(back_cnt_w))
      else $error("handwheel count moved without a pulse");

   a_func_lamp: assert property (
      @(posedge clk_sys_i) disable iff (rst_i) (fk_cmd_ff[7:6] == LAMP_ON) |=> func_lamp_o[3])
      else $error("function key lamp not lit on the on command");
   a_func_dark: assert property (
      @(posedge clk_sys_i) disable iff (rst_i) (fk_cmd_ff[1:0] == LAMP_OFF) |=> !func_lamp_o[0])
      else $error("function key lamp lit on the off command");

   a_link_restore: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      s_link_rise |=> image_ff == ($past(restore_ff) & IMAGE_MASK))
      else $error("restored values not loaded at link up");

   a_image_hold: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      (link_ff && link_prev_ff && chg_w == ZERO_WORD) |=> $stable(image_ff))
      else $error("image changed after link up without an element change");

   a_bus_answer: assert property (
      @(posedge clk_sys_i) disable iff (rst_i)
      acc_w |=> s_one_answer)
      else $error("waitrequest not low for exactly one cycle");

endmodule

// ==== rtl/panel_image_pkg.sv ====
// constants shared by the operator panel input image logic
package panel_image_pkg;

   // ---------------------------------------------------------------
   // clock and timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_HZ         = 25_000_000;
   localparam int unsigned CLK_PER_MS     = CLK_HZ / 1000;
   localparam int unsigned FAST_HALF_MS   = 125;   // fast flash, half period
   localparam int unsigned SLOW_HALF_MS   = 500;   // slow flash, half period
   localparam int unsigned FAST_HALF_CYC  = FAST_HALF_MS * CLK_PER_MS;
   localparam int unsigned SLOW_HALF_CYC  = SLOW_HALF_MS * CLK_PER_MS;
   localparam int unsigned DIV_W          = 24;

   // ---------------------------------------------------------------
   // register byte addresses
   // ---------------------------------------------------------------
   localparam logic [4:0] ADDR_IMAGE      = 5'h00;  // bytes n..n+3
   localparam logic [4:0] ADDR_COUNT      = 5'h04;  // bytes n+4, n+5
   localparam logic [4:0] ADDR_BTN_LAMP   = 5'h08;
   localparam logic [4:0] ADDR_FK_LAMP_LO = 5'h0C;  // keys 1..16
   localparam logic [4:0] ADDR_FK_LAMP_HI = 5'h10;  // keys 17..18
   localparam logic [4:0] ADDR_LINK       = 5'h14;
   localparam logic [4:0] ADDR_RESTORE    = 5'h18;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int unsigned NUM_FKEYS      = 18;
   localparam int unsigned FK_LSB         = 0;      // func_key_first at bit 0
   localparam int unsigned SW_LOW_BIT     = 24;     // keyswitch_code_low
   localparam int unsigned SW_HIGH_BIT    = 25;     // keyswitch_code_high
   localparam int unsigned BTN_LEFT_BIT   = 26;     // left_lit_button
   localparam int unsigned BTN_RIGHT_BIT  = 28;     // right_lit_button
   localparam int unsigned LAMP_LEFT_BIT  = 1;
   localparam int unsigned LAMP_RIGHT_BIT = 2;
   localparam int unsigned FWD_LSB        = 0;      // fwd_count_lsb
   localparam int unsigned BACK_LSB       = 8;      // back_count_lsb
   localparam int unsigned LINK_BIT       = 0;
   localparam logic [31:0] IMAGE_MASK     = 32'h1703_FFFF;

   // ---------------------------------------------------------------
   // reset values and lamp command codes
   // ---------------------------------------------------------------
   localparam logic [31:0] ZERO_WORD      = 32'h0000_0000;
   localparam logic [1:0]  LAMP_OFF       = 2'h0;
   localparam logic [1:0]  LAMP_FAST      = 2'h1;
   localparam logic [1:0]  LAMP_SLOW      = 2'h2;
   localparam logic [1:0]  LAMP_ON        = 2'h3;

endpackage

// ==== rtl/sync_edge.sv ====
// two-stage synchroniser with change detection on the settled level
`timescale 1ns/1ps
module sync_edge #(
   parameter int unsigned W = 1
) (
   input  wire logic         clk_sys_i,
   input  wire logic         rst_i,
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] level_o,
   output logic      [W-1:0] prev_o
);
   logic [W-1:0] meta_ff;

   // meta_ff feeds only level_o; edges are taken between level and prev
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         meta_ff <= '0;
         level_o <= '0;
         prev_o  <= '0;
      end else begin
         meta_ff <= async_i;
         level_o <= meta_ff;
         prev_o  <= level_o;
      end
   end
endmodule

// ==== rtl/wrap_count8.sv ====
// eight-bit wrap-around pulse counter, cleared only by reset
`timescale 1ns/1ps
module wrap_count8 (
   input  wire logic       clk_sys_i,
   input  wire logic       rst_i,
   input  wire logic       inc_i,
   output logic      [7:0] count_o
);
   // no load port: the count moves only on pulses and reset
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         count_o <= 8'h00;
      end else if (inc_i) begin
         count_o <= 8'(count_o + 8'h01);
      end
   end
endmodule
